// *** rtl/breakpoint_watchpoint_trigger.sv ***
// Summary of operation
// - Trigger unit starts/stops trace on a hit of the selected enabled comparator (1 to 7)
// - Start trigger sets trace mode bits
// - Omit starting data event, keep ending one
// - Hit message: code 15, 8-bit vector
// - Trace hit message: code 56, 2-bit vector
// - Six instruction address comparator registers
// - Enable field: off, breakpoint, watchpoint
// - Mask enable masks A compare, silences B
// - Event pin control bit, read-only
// - Optional address space identifier qualification
// - Double word enable joins data comparators
// - Range select: none, exclusive, inclusive
// - Two data addresses, reset zero
// - Two data values, reset zero
// - Program trace only while trace bit set
// - Four 3-bit trigger selectors, zero disables
`default_nettype none
module breakpoint_watchpoint_trigger
    import bwt_pkg::*;
#(
    parameter logic [5:0] EVT_OUT_MASK = 6'h00
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire fetch_t             fetch_i,
    input  wire data_access_t       data_i,
    input  wire logic [7:0]         asid_i,
    output logic                    breakpoint_o,
    output logic                    event_out_pin_o,
    output logic                    hit_msg_valid_o,
    output hit_message_t            hit_msg_o,
    output logic                    trace_hit_valid_o,
    output trace_hit_message_t      trace_hit_msg_o,
    output logic                    prog_trace_valid_o,
    output logic      [31:0]        prog_trace_pc_o,
    output logic                    data_trace_valid_o,
    output data_access_t            data_trace_o,
    output logic                    prog_trace_en_o,
    output logic                    data_trace_en_o,
    output logic                    irq_o
);

    // ==========================================================
    // Helpers
    function automatic logic asid_ok(input logic [31:0] ctl, input logic [7:0] asid);
        return !ctl[SPACE_ID_MATCH_EN_BIT] || (ctl[ASID_LO+7:ASID_LO] == asid);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                          input logic [3:0] sel, input logic [31:0] wmask);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = wdat[8*b +: 8];
            end
        end
        return res & wmask;
    endfunction

    function automatic logic fires(input logic [2:0] sel, input logic [7:0] vec);
        return (sel != SEL_OFF) && vec[sel];
    endfunction

    // ==========================================================
    // Bus decode
    logic        ack_r;
    logic [31:0] rdata_r;
    logic        take;
    logic        wr;
    logic        rd;
    logic        pc_addr_sel;
    logic        pc_ctrl_sel;
    logic [2:0]  pc_idx;

    assign take        = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr          = take && wb_we_i;
    assign rd          = take && !wb_we_i;
    assign pc_idx      = wb_adr_i[4:2];
    assign pc_addr_sel = (wb_adr_i[7:5] == PC_ADDR_BASE[7:5]) && (pc_idx < 3'h6);
    assign pc_ctrl_sel = (wb_adr_i[7:5] == PC_CTRL_BASE[7:5]) && (pc_idx < 3'h6);

    // ==========================================================
    // Comparator registers
    logic [31:0] pc_addr_r [6];
    logic [31:0] pc_ctl_r  [6];
    logic [31:0] daddr_r   [2];
    logic [31:0] dval_r    [2];
    logic [31:0] dctl_r    [2];
    logic [31:0] pair_r;
    logic [31:0] trig_r;

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 6; i++) begin
            if (rst_i) begin
                pc_addr_r[i] <= REG_RESET;
            end else if (wr && pc_addr_sel && pc_idx == 3'(i)) begin
                pc_addr_r[i] <= merge(pc_addr_r[i], wb_dat_i, wb_sel_i, '1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < 6; i++) begin
            if (rst_i) begin
                pc_ctl_r[i] <= REG_RESET;
            end else if (wr && pc_ctrl_sel && pc_idx == 3'(i)) begin
                pc_ctl_r[i] <= merge(pc_ctl_r[i], wb_dat_i, wb_sel_i,
                                     (i % 2 == 0) ? PC_CTRL_A_WMASK : PC_CTRL_B_WMASK);
            end
        end
    end

    // Data address, value and control words
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            daddr_r <= '{REG_RESET, REG_RESET};
            dval_r  <= '{REG_RESET, REG_RESET};
            dctl_r  <= '{REG_RESET, REG_RESET};
            pair_r  <= REG_RESET;
            trig_r  <= REG_RESET;
        end else if (wr) begin
            case (wb_adr_i)
                DADDR_A_OFF:   daddr_r[0] <= merge(daddr_r[0], wb_dat_i, wb_sel_i, '1);
                DADDR_B_OFF:   daddr_r[1] <= merge(daddr_r[1], wb_dat_i, wb_sel_i, '1);
                DVAL_A_OFF:    dval_r[0]  <= merge(dval_r[0], wb_dat_i, wb_sel_i, '1);
                DVAL_B_OFF:    dval_r[1]  <= merge(dval_r[1], wb_dat_i, wb_sel_i, '1);
                DCTRL_A_OFF:   dctl_r[0]  <= merge(dctl_r[0], wb_dat_i, wb_sel_i, DCTRL_WMASK);
                DCTRL_B_OFF:   dctl_r[1]  <= merge(dctl_r[1], wb_dat_i, wb_sel_i, DCTRL_WMASK);
                PAIR_CTRL_OFF: pair_r     <= merge(pair_r, wb_dat_i, wb_sel_i, PAIR_WMASK);
                TRIG_OFF:      trig_r     <= merge(trig_r, wb_dat_i, wb_sel_i, TRIG_WMASK);
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Instruction comparators
    logic [7:0] match;
    logic [5:0] pc_m;
    logic [1:0] dm;
    logic       b_pend_r;

    always_comb begin
        pc_m = '0;
        for (int p = 0; p < 3; p++) begin
            if (pc_ctl_r[2*p][AME_BIT]) begin
                pc_m[2*p]   = (fetch_i.pc & pc_addr_r[2*p+1]) ==
                              (pc_addr_r[2*p] & pc_addr_r[2*p+1]);
                pc_m[2*p+1] = 1'b0;
            end else begin
                pc_m[2*p]   = fetch_i.pc == pc_addr_r[2*p];
                pc_m[2*p+1] = fetch_i.pc == pc_addr_r[2*p+1];
            end
        end
        for (int i = 0; i < 6; i++) begin
            pc_m[i] = pc_m[i] && fetch_i.valid && asid_ok(pc_ctl_r[i], asid_i);
        end
    end

    // ==========================================================
    // Data comparators
    logic       rng_on;
    logic       double_word_compare_en;
    logic [1:0] raw_dm;
    logic       in_range;

    assign rng_on = (pair_r[1:0] == RNG_EXCL) || (pair_r[1:0] == RNG_INCL);
    assign double_word_compare_en    = pair_r[DWE_BIT];

    // Range comparison on the data address
    always_comb begin
        case (pair_r[1:0])
            RNG_EXCL: in_range = (data_i.addr <= daddr_r[0]) || (data_i.addr > daddr_r[1]);
            RNG_INCL: in_range = (data_i.addr > daddr_r[0]) && (data_i.addr <= daddr_r[1]);
            default:  in_range = 1'b0;
        endcase
    end

    always_comb begin
        raw_dm = '0;
        for (int k = 0; k < 2; k++) begin
            logic [1:0] brw;
            logic [1:0] bwo;
            logic       addr_hit;
            brw      = dctl_r[k][BRW_LO +: 2];
            bwo      = dctl_r[k][BWO_LO +: 2];
            addr_hit = (k == 0 && rng_on) ? in_range : (data_i.addr == daddr_r[k]);
            raw_dm[k] = data_i.valid && (bwo != 2'h0) && asid_ok(dctl_r[k], asid_i)
                      && ((brw == BRW_ANY) || (brw == BRW_READ && !data_i.write)
                          || (brw == BRW_WRITE && data_i.write))
                      && (!bwo[1] || addr_hit) && (!bwo[0] || data_i.value == dval_r[k]);
        end
    end

    // Combined compare needs B's word, earlier or in the same access
    assign dm[0] = raw_dm[0] && (!double_word_compare_en || b_pend_r || raw_dm[1]);
    assign dm[1] = raw_dm[1] && !double_word_compare_en && !rng_on;

    // B word of a combined compare waits for the next data access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            b_pend_r <= 1'b0;
        end else if (data_i.valid) begin
            b_pend_r <= raw_dm[1] && double_word_compare_en;
        end
    end

    // ==========================================================
    // Hit classification
    logic [7:0] bp_vec;
    logic [7:0] wp_vec;
    logic [7:0] ena_vec;
    logic [31:0] ctl_of [8];

    assign match = {dm, pc_m};

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            ctl_of[i] = pc_ctl_r[i];
        end
        ctl_of[6] = dctl_r[0];
        ctl_of[7] = dctl_r[1];
        for (int i = 0; i < 8; i++) begin
            bp_vec[i]  = match[i] && (ctl_of[i][ENA_LO +: 2] == ENA_BREAK);
            wp_vec[i]  = match[i] && (ctl_of[i][ENA_LO +: 2] == ENA_WATCH);
            ena_vec[i] = match[i] && (ctl_of[i][ENA_LO +: 2] != 2'h0);
        end
    end

    // ==========================================================
    // Trigger unit
    logic pts_f;
    logic pte_f;
    logic dts_f;
    logic dte_f;
    logic [31:0] dev_ctl_r;

    assign pts_f = fires(trig_r[PTS_LO +: 3], ena_vec);
    assign pte_f = fires(trig_r[PTE_LO +: 3], ena_vec);
    assign dts_f = fires(trig_r[DTS_LO +: 3], ena_vec);
    assign dte_f = fires(trig_r[DTE_LO +: 3], ena_vec);

    // Trigger updates trace mode bits over software
    always_ff @(posedge clk_i) begin
        logic [31:0] nxt;
        nxt = dev_ctl_r;
        if (wr && wb_adr_i == DEV_CTRL_OFF) begin
            nxt = merge(dev_ctl_r, wb_dat_i, wb_sel_i, DEV_CTRL_WMASK);
        end
        if (pts_f) begin
            nxt[TM_PROG_BIT] = 1'b1;
        end else if (pte_f) begin
            nxt[TM_PROG_BIT] = 1'b0;
        end
        if (dts_f) begin
            nxt[TM_DATA_BIT] = 1'b1;
        end else if (dte_f) begin
            nxt[TM_DATA_BIT] = 1'b0;
        end
        if (rst_i) begin
            dev_ctl_r <= REG_RESET;
        end else begin
            dev_ctl_r <= nxt;
        end
    end

    // ==========================================================
    // Messages and trace outputs
    logic trig_any;
    assign trig_any = pts_f || pte_f || dts_f || dte_f;

    // Hit messages, watchpoint message has priority
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hit_msg_valid_o   <= 1'b0;
            hit_msg_o         <= '0;
            trace_hit_valid_o <= 1'b0;
            trace_hit_msg_o   <= '0;
        end else begin
            hit_msg_valid_o   <= |wp_vec;
            hit_msg_o         <= '{tcode: TCODE_HIT, hit_vector: wp_vec};
            trace_hit_valid_o <= trig_any && !(|wp_vec);
            trace_hit_msg_o   <= '{tcode: TCODE_TRACE_HIT,
                                   hit_vector: {pte_f || dte_f, pts_f || dts_f}};
        end
    end

    // Event pin follows read-only control bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            breakpoint_o    <= 1'b0;
            event_out_pin_o <= 1'b0;
        end else begin
            breakpoint_o    <= |bp_vec;
            event_out_pin_o <= |((bp_vec[5:0] | wp_vec[5:0]) & EVT_OUT_MASK);
        end
    end

    // Trace forwarding uses mode before this event
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prog_trace_valid_o <= 1'b0;
            prog_trace_pc_o    <= '0;
            data_trace_valid_o <= 1'b0;
            data_trace_o       <= '0;
            prog_trace_en_o    <= 1'b0;
            data_trace_en_o    <= 1'b0;
        end else begin
            prog_trace_valid_o <= fetch_i.valid && dev_ctl_r[TM_PROG_BIT];
            prog_trace_pc_o    <= fetch_i.pc;
            data_trace_valid_o <= data_i.valid && dev_ctl_r[TM_DATA_BIT];
            data_trace_o       <= data_i;
            prog_trace_en_o    <= dev_ctl_r[TM_PROG_BIT];
            data_trace_en_o    <= dev_ctl_r[TM_DATA_BIT];
        end
    end

    // ==========================================================
    // Interrupts
    logic [3:0] irq_stat_r;
    logic [3:0] irq_mask_r;
    logic [3:0] irq_ev;

    assign irq_ev = {trig_any, trace_hit_valid_o, hit_msg_valid_o, breakpoint_o};

    // Sticky status; a new event wins over the read clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_r <= '0;
        end else if (rd && wb_adr_i == IRQ_STAT_OFF) begin
            irq_stat_r <= irq_ev;
        end else begin
            irq_stat_r <= irq_stat_r | irq_ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_r <= '0;
            irq_o      <= 1'b0;
        end else begin
            if (wr && wb_adr_i == IRQ_MASK_OFF && wb_sel_i[0]) begin
                irq_mask_r <= wb_dat_i[3:0];
            end
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ==========================================================
    // Read back and acknowledge
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        if (pc_addr_sel) begin
            rd_mux = pc_addr_r[pc_idx];
        end else if (pc_ctrl_sel) begin
            rd_mux = pc_ctl_r[pc_idx];
            rd_mux[EOC_BIT] = EVT_OUT_MASK[pc_idx];
        end else begin
            case (wb_adr_i)
                PAIR_CTRL_OFF: rd_mux = pair_r;
                DADDR_A_OFF:   rd_mux = daddr_r[0];
                DADDR_B_OFF:   rd_mux = daddr_r[1];
                DVAL_A_OFF:    rd_mux = dval_r[0];
                DVAL_B_OFF:    rd_mux = dval_r[1];
                DCTRL_A_OFF:   rd_mux = dctl_r[0];
                DCTRL_B_OFF:   rd_mux = dctl_r[1];
                TRIG_OFF:      rd_mux = trig_r;
                DEV_CTRL_OFF:  rd_mux = dev_ctl_r;
                IRQ_STAT_OFF:  rd_mux = {28'h0000000, irq_stat_r};
                IRQ_MASK_OFF:  rd_mux = {28'h0000000, irq_mask_r};
                default:       rd_mux = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= take;
            if (rd) begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    // ==========================================================
    // Checks
    property p_hit_tcode;
        @(posedge clk_i) disable iff (rst_i)
        hit_msg_valid_o |-> hit_msg_o.tcode == 6'h0f && hit_msg_o.hit_vector != 8'h00;
    endproperty
    a_hit_tcode: assert property (p_hit_tcode) else $error("bad hit message");

    property p_hit_vec;
        @(posedge clk_i) disable iff (rst_i)
        (|wp_vec) |=> hit_msg_valid_o && hit_msg_o.hit_vector == $past(wp_vec);
    endproperty
    a_hit_vec: assert property (p_hit_vec) else $error("hit vector lost");

    property p_trace_hit;
        @(posedge clk_i) disable iff (rst_i)
        (trig_any && !(|wp_vec)) |=> trace_hit_valid_o && trace_hit_msg_o.tcode == 6'h38;
    endproperty
    a_trace_hit: assert property (p_trace_hit) else $error("bad trace hit");

    property p_start;
        @(posedge clk_i) disable iff (rst_i)
        pts_f |=> dev_ctl_r[TM_PROG_BIT] ##1 prog_trace_en_o;
    endproperty
    a_start: assert property (p_start) else $error("trace start missed");

    property p_data_omit;
        @(posedge clk_i) disable iff (rst_i)
        (data_i.valid && dts_f && !dev_ctl_r[TM_DATA_BIT]) |=> !data_trace_valid_o;
    endproperty
    a_data_omit: assert property (p_data_omit) else $error("start event traced");

    property p_data_keep;
        @(posedge clk_i) disable iff (rst_i)
        (data_i.valid && dev_ctl_r[TM_DATA_BIT]) |=> data_trace_valid_o;
    endproperty
    a_data_keep: assert property (p_data_keep) else $error("data event dropped");

    property p_prog_gate;
        @(posedge clk_i) disable iff (rst_i)
        prog_trace_valid_o |-> $past(dev_ctl_r[TM_PROG_BIT]);
    endproperty
    a_prog_gate: assert property (p_prog_gate) else $error("trace while off");

    property p_mask_b;
        @(posedge clk_i) disable iff (rst_i)
        pc_ctl_r[0][AME_BIT] |=> !hit_msg_o.hit_vector[1] || $past(!pc_ctl_r[0][AME_BIT], 2);
    endproperty
    a_mask_b: assert property (p_mask_b) else $error("masked B fired");

    property p_asid;
        @(posedge clk_i) disable iff (rst_i)
        (pc_ctl_r[0][SPACE_ID_MATCH_EN_BIT] && asid_i != pc_ctl_r[0][8:1]) |=> !hit_msg_o.hit_vector[0];
    endproperty
    a_asid: assert property (p_asid) else $error("identifier ignored");

    property p_dwe;
        @(posedge clk_i) disable iff (rst_i)
        (double_word_compare_en && !b_pend_r && !raw_dm[1]) |-> !dm[0] && !dm[1];
    endproperty
    a_dwe: assert property (p_dwe) else $error("single word hit in pair mode");

    property p_reserved;
        @(posedge clk_i) disable iff (rst_i)
        (pc_ctl_r[1] & ~PC_CTRL_B_WMASK) == 32'h0 && (trig_r & ~TRIG_WMASK) == 32'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

endmodule
`default_nettype wire

// *** common/bwt_pkg.sv ***
`default_nettype none
package bwt_pkg;

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] PC_ADDR_BASE   = 8'h00;
    localparam logic [7:0] PC_CTRL_BASE   = 8'h20;
    localparam logic [7:0] PAIR_CTRL_OFF  = 8'h40;
    localparam logic [7:0] DADDR_A_OFF    = 8'h44;
    localparam logic [7:0] DADDR_B_OFF    = 8'h48;
    localparam logic [7:0] DVAL_A_OFF     = 8'h4c;
    localparam logic [7:0] DVAL_B_OFF     = 8'h50;
    localparam logic [7:0] DCTRL_A_OFF    = 8'h54;
    localparam logic [7:0] DCTRL_B_OFF    = 8'h58;
    localparam logic [7:0] TRIG_OFF       = 8'h5c;
    localparam logic [7:0] DEV_CTRL_OFF   = 8'h60;
    localparam logic [7:0] IRQ_STAT_OFF   = 8'h64;
    localparam logic [7:0] IRQ_MASK_OFF   = 8'h68;

    // ==========================================================
    // Field positions
    localparam int ENA_LO      = 30;
    localparam int BRW_LO      = 28;
    localparam int AME_BIT     = 25;
    localparam int BWO_LO      = 16;
    localparam int EOC_BIT     = 14;
    localparam int ASID_LO     = 1;
    localparam int SPACE_ID_MATCH_EN_BIT  = 0;
    localparam int DWE_BIT     = 2;
    localparam int PTS_LO      = 29;
    localparam int PTE_LO      = 26;
    localparam int DTS_LO      = 23;
    localparam int DTE_LO      = 20;
    localparam int TM_PROG_BIT = 2;
    localparam int TM_DATA_BIT = 1;

    // ==========================================================
    // Writable bits, field codes, reset value
    localparam logic [31:0] PC_CTRL_A_WMASK = 32'hc20001ff;
    localparam logic [31:0] PC_CTRL_B_WMASK = 32'hc00001ff;
    localparam logic [31:0] DCTRL_WMASK     = 32'hf00301ff;
    localparam logic [31:0] PAIR_WMASK      = 32'h00000007;
    localparam logic [31:0] TRIG_WMASK      = 32'hfff00000;
    localparam logic [31:0] DEV_CTRL_WMASK  = 32'h00000006;
    localparam logic [31:0] REG_RESET       = 32'h00000000;
    localparam logic [1:0]  ENA_BREAK       = 2'h1;
    localparam logic [1:0]  ENA_WATCH       = 2'h3;
    localparam logic [1:0]  RNG_EXCL        = 2'h1;
    localparam logic [1:0]  RNG_INCL        = 2'h2;
    localparam logic [1:0]  BRW_READ        = 2'h0;
    localparam logic [1:0]  BRW_WRITE       = 2'h1;
    localparam logic [1:0]  BRW_ANY         = 2'h2;
    localparam logic [5:0]  TCODE_HIT       = 6'h0f;
    localparam logic [5:0]  TCODE_TRACE_HIT = 6'h38;
    localparam logic [2:0]  SEL_OFF         = 3'h0;

    // Interrupt status bit positions
    localparam int IRQ_BREAK = 0;
    localparam int IRQ_WATCH = 1;
    localparam int IRQ_TRACE = 2;
    localparam int IRQ_TRIG  = 3;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic        valid;
        logic [31:0] pc;
    } fetch_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] value;
    } data_access_t;

    typedef struct packed {
        logic [5:0] tcode;
        logic [7:0] hit_vector;
    } hit_message_t;

    typedef struct packed {
        logic [5:0] tcode;
        logic [1:0] hit_vector;
    } trace_hit_message_t;

endpackage
`default_nettype wire

// *** sim/msg_sink.sv ***
`default_nettype none
// Debug tool side: counts and checks incoming hit messages
module msg_sink
    import bwt_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               hit_valid_i,
    input  wire hit_message_t       hit_msg_i,
    input  wire logic               trace_valid_i,
    input  wire trace_hit_message_t trace_msg_i,
    output int                      hits_o,
    output int                      bad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial hits_o = 0;
    initial bad_o = 0;
    always @(posedge clk_i) begin
        if (hit_valid_i === 1'b1) begin
            hits_o <= hits_o + 1;
            if (hit_msg_i.tcode !== 6'd15) bad_o <= bad_o + 1;
        end
        if (trace_valid_i === 1'b1 && trace_msg_i.tcode !== 6'd56) bad_o <= bad_o + 1;
    end
endmodule
`default_nettype wire

// *** sim/tb_breakpoint_watchpoint_trigger.sv ***
`default_nettype none
module tb_breakpoint_watchpoint_trigger;
    timeunit 1ns;
    timeprecision 1ps;
    import bwt_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 0, asid = 0, lf = 8'h53;
    logic [31:0] dw = 0, dr, q, pc;
    logic ack, bp, hv, thv, pte, irq;
    hit_message_t hm;
    trace_hit_message_t thm;
    fetch_t fe = '0;
    data_access_t da = '0;
    int fail_count = 0, check_count = 0, cyc_n = 0, hits, bad;
    breakpoint_watchpoint_trigger breakpoint_watchpoint_trigger_i (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .fetch_i(fe),
        .data_i(da), .asid_i(asid), .breakpoint_o(bp), .event_out_pin_o(),
        .hit_msg_valid_o(hv), .hit_msg_o(hm), .trace_hit_valid_o(thv),
        .trace_hit_msg_o(thm), .prog_trace_valid_o(), .prog_trace_pc_o(),
        .data_trace_valid_o(), .data_trace_o(), .prog_trace_en_o(pte),
        .data_trace_en_o(), .irq_o(irq));
    msg_sink msg_sink_i (.clk_i(clk_i), .hit_valid_i(hv), .hit_msg_i(hm),
        .trace_valid_i(thv), .trace_msg_i(thm), .hits_o(hits), .bad_o(bad));
    // Clock and hang guard
    initial forever #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n > 5000) begin
            fail_count++;
            end_sim();
        end
    end
    // ==========================================================
    // Shared tasks
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = dr;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        wb(1'b0, a, 32'h0);
        chk(n, e, q);
    endtask
    task automatic fetch(input logic [31:0] p);
        @(posedge clk_i);
        fe <= {1'b1, p};
        @(posedge clk_i);
        fe.valid <= 1'b0;
        @(negedge clk_i);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(DADDR_B_OFF, 32'h0, "daddr_rst");
        rd(DVAL_B_OFF, 32'h0, "dval_rst");
        for (int i = 0; i < 4; i++) begin
            lf = lfsr(lf);
            wb(1'b1, DVAL_A_OFF, {4{lf}});
            rd(DVAL_A_OFF, {4{lf}}, "dval_rw");
        end
        wb(1'b1, PC_CTRL_BASE, 32'hffffffff);
        wb(1'b1, PC_CTRL_BASE + 8'h4, 32'hffffffff);
        rd(PC_CTRL_BASE, 32'hc20001ff, "ctrl_a");
        rd(PC_CTRL_BASE + 8'h4, 32'hc00001ff, "ctrl_b");
        wb(1'b1, PC_CTRL_BASE + 8'h4, 32'h0);
        rd(8'hfc, 32'h0, "unmapped");
        pc = {lf, 24'h000100};
        wb(1'b1, PC_ADDR_BASE, pc);
        wb(1'b1, PC_CTRL_BASE, 32'hc00000b5);
        wb(1'b1, IRQ_MASK_OFF, 32'h2);
        fetch(pc);
        chk("asid_miss", 32'h0, hv);
        @(posedge clk_i);
        asid <= 8'h5a;
        fetch(pc);
        chk("hit_msg", {1'b1, 17'h0, 6'd15, 8'h01}, {hv, 17'h0, hm});
        repeat (2) @(negedge clk_i);
        chk("irq", 32'h1, irq);
        rd(IRQ_STAT_OFF, 32'h2, "stat");
        rd(IRQ_STAT_OFF, 32'h0, "stat_clr");
        wb(1'b1, PC_CTRL_BASE, 32'h40000000);
        fetch(pc);
        chk("bp", 32'h1, {hv, bp});
        wb(1'b1, PC_CTRL_BASE, 32'h0);
        wb(1'b1, PC_ADDR_BASE + 8'h4, pc + 4);
        wb(1'b1, PC_CTRL_BASE + 8'h4, 32'hc0000000);
        wb(1'b1, TRIG_OFF, 32'h20000000);
        fetch(pc + 4);
        chk("vec_1", 32'h02, hm.hit_vector);
        rd(DEV_CTRL_OFF, 32'h4, "tm");
        chk("prog_en", 32'h1, pte);
        wb(1'b1, TRIG_OFF, 32'hffffffff);
        rd(TRIG_OFF, 32'hfff00000, "trig");
        wb(1'b1, TRIG_OFF, 32'h0);
        wb(1'b1, DADDR_A_OFF, 32'h8010);
        wb(1'b1, DCTRL_A_OFF, 32'he0020000);
        @(posedge clk_i);
        da <= {1'b1, 1'b1, 32'h8010, 32'h0};
        @(posedge clk_i);
        da.valid <= 1'b0;
        @(negedge clk_i);
        chk("vec_6", 32'h40, hm.hit_vector);
        @(negedge clk_i);
        chk("sink", 32'h3, hits + bad);
        end_sim();
    end
endmodule
`default_nettype wire
